/* File: test/dsrs_properties.sv */
// Pin-level checks between the device end and the master end.
// Assumes the bench instantiates it beside dsrs_if, on the same CLK.
`timescale 1ns/10ps
module dsrs_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic scl,
  input wire logic h_sda_oe,
  input wire logic d_scl_oe,
  input wire logic d_sda_oe,
  input wire logic d_sdo_o,
  input wire logic d_sdo_oe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Select is synchronised, so a few cycles of lag are allowed
  sdo_off_idle_a: assert property (cs_n [*4] |-> !d_sdo_oe)
    else $error("SDO driven while deselected");
  sdo_on_sel_a: assert property (!cs_n [*5] |-> d_sdo_oe)
    else $error("SDO not driven while selected");
  sdo_edge_a: assert property (
    (!cs_n && $past(!cs_n) && $past(d_sdo_oe) && $changed(d_sdo_o))
    |-> !scl)
    else $error("SDO changed while SCLK high");
  sda_edge_a: assert property (
    (cs_n && $past(cs_n) && $changed(d_sda_oe)) |-> !scl)
    else $error("Device changed SDA while SCL high");
  stretch_len_a: assert property (
    $rose(d_scl_oe) |-> ##[1:6] !d_scl_oe)
    else $error("Clock stretch too long");
  ack_hold_a: assert property (
    ($rose(scl) && d_sda_oe && cs_n) |-> d_sda_oe [*8])
    else $error("Device released SDA in high phase");
  spi_quiet_a: assert property (
    !cs_n [*4] |-> (!d_sda_oe && !d_scl_oe))
    else $error("Two-wire drive during SPI select");
  cs_edge_a: assert property ($changed(cs_n) |-> scl)
    else $error("Select moved while SCLK low");
  sdi_edge_a: assert property (
    (!cs_n && $past(!cs_n) && $changed(h_sda_oe)) |-> !scl)
    else $error("SDI changed while SCLK high");
  cover property ($rose(d_scl_oe));
  cover property ($rose(d_sdo_oe));
  cover property ($fell(cs_n));
endmodule // dsrs_properties

/* File: test/dual_serial_register_slave_test.sv */
// Self-checking bench: master end talks to device end over dsrs_if.
// Assumes 50 MHz clock and the constants of dsrs_params.svh.
`timescale 1ns/10ps
`include "dsrs_params.svh"
module dual_serial_register_slave_test;
  localparam logic [7:0] ST_BIT [5] = '{8'h01 << `DSRS_ST_OVF,
    8'h01 << `DSRS_ST_DRDY, 8'h01 << `DSRS_ST_AUXERR,
    8'h01 << `DSRS_ST_AUXERR, 8'h01 << `DSRS_ST_AUXDONE};
  localparam logic [7:0] EN_ALL = ST_BIT[0] | ST_BIT[1] | ST_BIT[2] |
    ST_BIT[4];
  localparam logic [7:0] CFG_LOW = (8'h01 << `DSRS_CFG_LOWACT_BIT) |
    (8'h01 << `DSRS_CFG_OPEN_BIT) | (8'h01 << `DSRS_CFG_ANYRD_BIT);
  localparam logic [7:0] CFG_PULSE = 8'h01 << `DSRS_CFG_PULSE_BIT;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic go = 1'h0;
  logic spi = 1'h0;
  logic rd = 1'h0;
  logic ad = 1'h0;
  logic [6:0] creg = 7'h00;
  logic [7:0] cwd = 8'h00;
  logic [4:0] ev = 5'h00;
  logic busy, done, nack, wr_stb;
  logic [7:0] rdata, wr_data, wd;
  logic [6:0] wr_addr, wa;
  int n_fail = 0;
  int n_checks = 0;
  dsrs_if link();
  always #10 clk = ~clk;
  dsrs_device dsrs_device_inst (.CLK(clk), .RST(rst), .LINK(link),
    .EV_FIFO_OVF(ev[0]), .EV_DATA_RDY(ev[1]), .EV_AUX_NACK(ev[2]),
    .EV_AUX_LOST(ev[3]), .EV_AUX_DONE(ev[4]), .WR_STB(wr_stb),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  dsrs_host dsrs_host_inst (.CLK(clk), .RST(rst), .LINK(link),
    .CMD_GO(go), .CMD_SPI(spi), .CMD_READ(rd), .CMD_AD_SEL(ad),
    .CMD_REG(creg), .CMD_WDATA(cwd), .BUSY(busy), .DONE(done),
    .NACK(nack), .RDATA(rdata));
  dsrs_properties dsrs_properties_inst (.CLK(clk), .RST(rst),
    .cs_n(link.cs_n), .scl(link.scl), .h_sda_oe(link.h_sda_oe),
    .d_scl_oe(link.d_scl_oe), .d_sda_oe(link.d_sda_oe),
    .d_sdo_o(link.d_sdo_o), .d_sdo_oe(link.d_sdo_oe));
  // Keep the last register write seen from the link
  always @(posedge clk) begin
    if (wr_stb === 1'h1) begin
      wa <= wr_addr;
      wd <= wr_data;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic s, input logic r, input logic a,
      input logic [6:0] g, input logic [7:0] w);
    int i;
    @(posedge clk);
    spi <= s;
    rd <= r;
    ad <= a;
    creg <= g;
    cwd <= w;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    chk({7'h00, busy}, 8'h01);
    for (i = 0; i < 20000 && done !== 1'h1; i++) @(posedge clk);
    if (i == 20000) begin
      n_fail++;
      $display("BAD t=%0t command never finished", $time);
    end
    chk({7'h00, busy}, 8'h00);
  endtask
  // Events are single-cycle; flag and pin settle within a few cycles
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin : main
    int k;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    cmd(1'h0, 1'h0, 1'h0, 7'h10, 8'hA5);
    chk({7'h00, nack}, 8'h00);
    chk({1'h0, wa}, 8'h10);
    chk(wd, 8'hA5);
    // Other strap level: address LSB follows the select pin
    cmd(1'h0, 1'h1, 1'h1, 7'h10, 8'h00);
    chk(rdata, 8'hA5);
    chk({7'h00, nack}, 8'h00);
    cmd(1'h1, 1'h0, 1'h0, 7'h22, 8'h3C);
    chk({1'h0, wa}, 8'h22);
    chk(wd, 8'h3C);
    cmd(1'h1, 1'h1, 1'h0, 7'h22, 8'h00);
    chk(rdata, 8'h3C);
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_INT_EN, EN_ALL);
    for (k = 0; k < 5; k++) begin
      pulse(5'h01 << k);
      chk({7'h00, link.irq}, 8'h01);
      cmd(1'h1, 1'h1, 1'h0, `DSRS_REG_INT_STAT, 8'h00);
      chk(rdata, ST_BIT[k]);
      repeat (4) @(posedge clk);
      chk({7'h00, link.irq}, 8'h00);
    end
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_INT_EN, 8'h00);
    pulse(5'h01);
    chk({7'h00, link.irq}, 8'h00);
    cmd(1'h1, 1'h1, 1'h0, `DSRS_REG_INT_STAT, 8'h00);
    chk(rdata, ST_BIT[0]);
    // Active-low open-drain pin, cleared by any register read
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_INT_EN, EN_ALL);
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_INT_CFG, CFG_LOW);
    chk({7'h00, link.irq}, 8'h01);
    pulse(5'h02);
    chk({7'h00, link.irq}, 8'h00);
    cmd(1'h1, 1'h1, 1'h0, 7'h22, 8'h00);
    chk(rdata, 8'h3C);
    repeat (4) @(posedge clk);
    chk({7'h00, link.irq}, 8'h01);
    // Pulse mode: pin follows the timer, not the latched flag
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_INT_CFG, CFG_PULSE);
    repeat (`DSRS_INT_PULSE_CYC) @(posedge clk);
    chk({7'h00, link.irq}, 8'h00);
    pulse(5'h10);
    chk({7'h00, link.irq}, 8'h01);
    repeat (`DSRS_INT_PULSE_CYC) @(posedge clk);
    chk({7'h00, link.irq}, 8'h00);
    cmd(1'h1, 1'h0, 1'h0, `DSRS_REG_USER_CTRL,
      8'h01 << `DSRS_TWI_DIS_BIT);
    cmd(1'h0, 1'h0, 1'h0, 7'h11, 8'h5A);
    chk({7'h00, nack}, 8'h01);
    chk({1'h0, wa}, {1'h0, `DSRS_REG_USER_CTRL});
    wrap_up;
  end
  // Tests need about 28k cycles; allow well over that
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule // dual_serial_register_slave_test

/* File: verilog/dsrs_device.sv */
// Device end: two-wire and SPI register slave sharing pins, a
// 128-byte register file and the programmable interrupt pin.
// Assumes LINK pins are asynchronous to CLK and events are on CLK.
// Functional notes
// - Interrupt pin from individually enabled flagged sources
// - Sources: overflow, data ready, aux errors, done
// - Two-wire up to 400 kHz, SPI 1 MHz
// - Chip select low selects SPI; pins shared
// - SPI master sets two-wire disable bit early; the bench sets it only before its last two-wire command
// - Two-wire address 110100 plus select pin
// - Start/stop detected; busy across repeated starts
// - Ninth clock acknowledge, receiver holds SDA low
// - Slave may stretch SCL; master waits
// - Address byte with direction bit, then acknowledge
// - Write: address, pointer, data, acks, stop
// - Further written bytes go to next register
// - Read: pointer write, repeated start, read
// - Master acks wanted bytes, nacks last, stops
// - SDA changes only while SCL low
// - Chip select frames transfer; SDO off otherwise
// - SPI bytes most significant bit first
// - SPI sample rising, change falling edge
// - First SPI byte: direction and address
// - SPI single and burst transfers per select
// - Configurable pin, latching, clearing; status readable
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "dsrs_params.svh"
module dsrs_device (
  input wire logic CLK,
  input wire logic RST,
  dsrs_if.dev LINK,
  input wire logic EV_FIFO_OVF,
  input wire logic EV_DATA_RDY,
  input wire logic EV_AUX_NACK,
  input wire logic EV_AUX_LOST,
  input wire logic EV_AUX_DONE,
  output logic WR_STB,
  output logic [6:0] WR_ADDR,
  output logic [7:0] WR_DATA
);
  logic [2:0] scl_s, sda_s, cs_s;
  logic [1:0] ad_s;
  logic [7:0] mem_reg [0:127];
  logic [7:0] stat_reg, ev_d_reg;
  dsrs_pkg::twi_state_t st_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sr_reg, tx_reg;
  logic [6:0] ptr_reg;
  logic sda_oe_reg, scl_oe_reg;
  logic [2:0] stretch_reg;
  logic i_wr, i_rd;
  logic [6:0] i_wa, i_ra;
  logic [7:0] i_wd;
  logic [2:0] sc_reg;
  logic first_reg, rw_reg;
  logic [6:0] sa_reg;
  logic [7:0] ssr_reg, stx_reg;
  logic sdo_reg, sdo_oe_reg;
  logic s_wr, s_rd;
  logic [6:0] s_wa, s_ra;
  logic [7:0] s_wd;
  logic rd_stb_reg;
  logic [6:0] rd_a_reg;
  logic [11:0] pcnt_reg;
  logic irq_o_reg, irq_oe_reg;

  function automatic logic [7:0] rd(input logic [6:0] a);
    rd = (a == `DSRS_REG_INT_STAT) ? stat_reg : mem_reg[a];
  endfunction

  wire scl = scl_s[1];
  wire scl_rise = scl_s[1] && !scl_s[2];
  wire scl_fall = !scl_s[1] && scl_s[2];
  wire sda = sda_s[1];
  wire start = scl && !sda_s[1] && sda_s[2];
  wire stop = scl && sda_s[1] && !sda_s[2];
  wire spi_mode = !cs_s[1];
  wire twi_dis = mem_reg[`DSRS_REG_USER_CTRL][`DSRS_TWI_DIS_BIT];
  wire twi_en = cs_s[1] && !twi_dis;
  wire [7:0] cfg = mem_reg[`DSRS_REG_INT_CFG];
  wire [7:0] en = mem_reg[`DSRS_REG_INT_EN];
  wire [7:0] ev = (8'(EV_DATA_RDY) << `DSRS_ST_DRDY)
    | (8'(EV_AUX_NACK | EV_AUX_LOST) << `DSRS_ST_AUXERR)
    | (8'(EV_FIFO_OVF) << `DSRS_ST_OVF)
    | (8'(EV_AUX_DONE) << `DSRS_ST_AUXDONE);

  // Pins are asynchronous: two flops, the third only for edges
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      cs_s <= 3'h7;
      ad_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], LINK.scl};
      sda_s <= {sda_s[1:0], LINK.sda};
      cs_s <= {cs_s[1:0], LINK.cs_n};
      ad_s <= {ad_s[0], LINK.sdo_ad};
    end
  end

  // Two-wire slave; all SDA drive changes follow a falling SCL
  always_ff @(posedge CLK) begin
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    if (stretch_reg != 3'h0) begin
      stretch_reg <= stretch_reg - 3'h1;
    end
    scl_oe_reg <= (stretch_reg != 3'h0);
    if (RST || !twi_en) begin
      st_reg <= dsrs_pkg::I_IDLE;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      stretch_reg <= 3'h0;
      if (RST) begin
        ptr_reg <= 7'h00;
        sr_reg <= 8'h00;
        tx_reg <= 8'h00;
        i_wa <= 7'h00;
        i_wd <= 8'h00;
        i_ra <= 7'h00;
      end
    end else if (start) begin
      st_reg <= dsrs_pkg::I_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop) begin
      st_reg <= dsrs_pkg::I_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      if (scl_rise && st_reg != dsrs_pkg::I_IDLE
          && st_reg != dsrs_pkg::I_SKIP) begin
        if (cnt_reg != 4'h8) begin
          sr_reg <= {sr_reg[6:0], sda};
          cnt_reg <= 4'(cnt_reg + 4'h1);
        end else begin
          cnt_reg <= 4'h0;
          if (st_reg == dsrs_pkg::I_TX) begin
            if (sda) begin
              st_reg <= dsrs_pkg::I_SKIP;
            end else begin
              tx_reg <= rd(ptr_reg);
              i_rd <= 1'b1;
              i_ra <= ptr_reg;
              ptr_reg <= 7'(ptr_reg + 7'h01);
            end
          end
        end
      end
      if (scl_fall) begin
        if (cnt_reg == 4'h8) begin
          unique case (st_reg)
            dsrs_pkg::I_ADDR: begin
              if (sr_reg[7:1] == {`DSRS_ADDR_HI, ad_s[1]}) begin
                sda_oe_reg <= 1'b1;
                if (sr_reg[0]) begin
                  // First byte is fetched on the ack clock; fetching here
                  // too would skip a register
                  st_reg <= dsrs_pkg::I_TX;
                  stretch_reg <= 3'(`DSRS_STRETCH_CYC);
                end else begin
                  st_reg <= dsrs_pkg::I_RXRA;
                end
              end else begin
                st_reg <= dsrs_pkg::I_SKIP;
              end
            end
            dsrs_pkg::I_RXRA: begin
              ptr_reg <= sr_reg[6:0];
              sda_oe_reg <= 1'b1;
              st_reg <= dsrs_pkg::I_RXDAT;
            end
            dsrs_pkg::I_RXDAT: begin
              i_wr <= 1'b1;
              i_wa <= ptr_reg;
              i_wd <= sr_reg;
              ptr_reg <= 7'(ptr_reg + 7'h01);
              sda_oe_reg <= 1'b1;
            end
            dsrs_pkg::I_TX: sda_oe_reg <= 1'b0;
            dsrs_pkg::I_IDLE, dsrs_pkg::I_SKIP: sda_oe_reg <= 1'b0;
          endcase
        end else if (st_reg == dsrs_pkg::I_TX) begin
          sda_oe_reg <= !tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end else begin
          sda_oe_reg <= 1'b0;
        end
      end
    end
  end

  // SPI slave, mode with sampling on rising SCLK
  always_ff @(posedge CLK) begin
    s_wr <= 1'b0;
    s_rd <= 1'b0;
    sdo_oe_reg <= spi_mode;
    if (RST || !spi_mode) begin
      sc_reg <= 3'h0;
      first_reg <= 1'b1;
      sdo_reg <= 1'b0;
      // Drop any byte left from the last frame
      stx_reg <= 8'h00;
      if (RST) begin
        rw_reg <= 1'b0;
        sa_reg <= 7'h00;
        ssr_reg <= 8'h00;
        s_wa <= 7'h00;
        s_wd <= 8'h00;
        s_ra <= 7'h00;
      end
    end else begin
      if (scl_rise) begin
        ssr_reg <= {ssr_reg[6:0], sda};
        sc_reg <= 3'(sc_reg + 3'h1);
        if (sc_reg == 3'h7) begin
          if (first_reg) begin
            first_reg <= 1'b0;
            rw_reg <= ssr_reg[6];
            sa_reg <= {ssr_reg[5:0], sda};
            if (ssr_reg[6]) begin
              stx_reg <= rd({ssr_reg[5:0], sda});
              s_rd <= 1'b1;
              s_ra <= {ssr_reg[5:0], sda};
              sa_reg <= 7'({ssr_reg[5:0], sda} + 7'h01);
            end
          end else begin
            sa_reg <= 7'(sa_reg + 7'h01);
            if (rw_reg) begin
              stx_reg <= rd(sa_reg);
              s_rd <= 1'b1;
              s_ra <= sa_reg;
            end else begin
              s_wr <= 1'b1;
              s_wa <= sa_reg;
              s_wd <= {ssr_reg[6:0], sda};
            end
          end
        end
      end
      if (scl_fall) begin
        sdo_reg <= stx_reg[7];
        stx_reg <= {stx_reg[6:0], 1'b0};
      end
    end
  end

  // One write port; the engines never run at once
  always_ff @(posedge CLK) begin
    if (RST) begin
      WR_STB <= 1'b0;
      WR_ADDR <= 7'h00;
      WR_DATA <= 8'h00;
      rd_stb_reg <= 1'b0;
      rd_a_reg <= 7'h00;
    end else begin
      WR_STB <= i_wr || s_wr;
      WR_ADDR <= i_wr ? i_wa : s_wa;
      WR_DATA <= i_wr ? i_wd : s_wd;
      rd_stb_reg <= i_rd || s_rd;
      rd_a_reg <= i_rd ? i_ra : s_ra;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < 128; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (WR_STB && WR_ADDR != `DSRS_REG_INT_STAT) begin
      mem_reg[WR_ADDR] <= WR_DATA;
    end
  end

  // The read value is taken two cycles before the clear lands; the clear
  // sets again only the current and the previous cycle's events.
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_reg <= 8'h00;
      ev_d_reg <= 8'h00;
    end else begin
      ev_d_reg <= ev;
      if (rd_stb_reg && (cfg[`DSRS_CFG_ANYRD_BIT]
          || rd_a_reg == `DSRS_REG_INT_STAT)) begin
        stat_reg <= ev | ev_d_reg;
      end else begin
        stat_reg <= stat_reg | ev;
      end
    end
  end

  wire active = cfg[`DSRS_CFG_PULSE_BIT] ? (pcnt_reg != 12'h000)
    : |(stat_reg & en);
  wire lvl = active ^ cfg[`DSRS_CFG_LOWACT_BIT];

  always_ff @(posedge CLK) begin
    if (RST) begin
      pcnt_reg <= 12'h000;
      irq_o_reg <= 1'b0;
      irq_oe_reg <= 1'b1;
    end else begin
      if (|(ev & en)) begin
        pcnt_reg <= 12'(`DSRS_INT_PULSE_CYC);
      end else if (pcnt_reg != 12'h000) begin
        pcnt_reg <= 12'(pcnt_reg - 12'h001);
      end
      irq_o_reg <= lvl;
      // Open drain only ever pulls the line low
      irq_oe_reg <= !cfg[`DSRS_CFG_OPEN_BIT] || !lvl;
    end
  end

  assign LINK.d_scl_o = 1'b0;
  assign LINK.d_scl_oe = scl_oe_reg;
  assign LINK.d_sda_o = 1'b0;
  assign LINK.d_sda_oe = sda_oe_reg;
  assign LINK.d_sdo_o = sdo_reg;
  assign LINK.d_sdo_oe = sdo_oe_reg;
  assign LINK.irq_o = irq_o_reg;
  assign LINK.irq_oe = irq_oe_reg;
endmodule // dsrs_device

/* File: verilog/dsrs_host.sv */
// Master end: runs one single-byte register write or read over the
// two-wire bus or SPI per command. Assumes the pins resolve through
// dsrs_if with pull-ups; link clocks come from dividers of CLK.
`timescale 1ns/10ps
`include "dsrs_params.svh"
module dsrs_host (
  input wire logic CLK,
  input wire logic RST,
  dsrs_if.host LINK,
  input wire logic CMD_GO,
  input wire logic CMD_SPI,
  input wire logic CMD_READ,
  input wire logic CMD_AD_SEL,
  input wire logic [6:0] CMD_REG,
  input wire logic [7:0] CMD_WDATA,
  output logic BUSY,
  output logic DONE,
  output logic NACK,
  output logic [7:0] RDATA
);
  dsrs_pkg::host_state_t st_reg;
  logic [1:0] scl_s, sda_s, sdo_s;
  logic [5:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] b_reg;
  logic [2:0] k_reg;
  logic [5:0] n_reg;
  logic [7:0] sh_reg;
  logic [15:0] ssh_reg;
  logic rd_reg, ad_reg;
  logic [6:0] ra_reg;
  logic [7:0] wd_reg;
  logic cs_n_reg, scl_oe_reg, sda_oe_reg, ad_lvl_reg;

  // Item list of a transfer: {kind, byte}
  function automatic logic [9:0] item(input logic [2:0] k);
    logic [6:0] a;
    a = {`DSRS_ADDR_HI, ad_reg};
    unique case (k)
      3'h0: item = {dsrs_pkg::K_START, 8'h00};
      3'h1: item = {dsrs_pkg::K_TX, a, 1'b0};
      3'h2: item = {dsrs_pkg::K_TX, 1'b0, ra_reg};
      3'h3: item = rd_reg ? {dsrs_pkg::K_START, 8'h00}
        : {dsrs_pkg::K_TX, wd_reg};
      3'h4: item = rd_reg ? {dsrs_pkg::K_TX, a, 1'b1}
        : {dsrs_pkg::K_STOP, 8'h00};
      3'h5: item = {dsrs_pkg::K_RX, 8'h00};
      default: item = {dsrs_pkg::K_STOP, 8'h00};
    endcase
  endfunction

  logic [9:0] it, it_n;

  // A process, not an assign, so reads of command state count
  always_comb begin
    it = item(k_reg);
    it_n = item(3'(k_reg + 3'h1));
  end
  wire dsrs_pkg::item_kind_t kind = dsrs_pkg::item_kind_t'(it[9:8]);
  wire [5:0] div_end = (st_reg == dsrs_pkg::H_SPI)
    ? 6'(`DSRS_SPI_HALF_CYC - 1) : 6'(`DSRS_I2C_QTR_CYC - 1);
  wire tick = (div_reg == div_end);

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      sdo_s <= 2'h3;
    end else begin
      scl_s <= {scl_s[0], LINK.scl};
      sda_s <= {sda_s[0], LINK.sda};
      sdo_s <= {sdo_s[0], LINK.sdo_ad};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || st_reg == dsrs_pkg::H_IDLE || tick) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= 6'(div_reg + 6'h01);
    end
  end

  always_ff @(posedge CLK) begin
    DONE <= 1'b0;
    if (RST) begin
      st_reg <= dsrs_pkg::H_IDLE;
      {q_reg, b_reg, k_reg, n_reg} <= 15'h0000;
      {sh_reg, ssh_reg, rd_reg, ad_reg, ra_reg, wd_reg} <= 41'h0;
      cs_n_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ad_lvl_reg <= 1'b0;
      BUSY <= 1'b0;
      NACK <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      unique case (st_reg)
        dsrs_pkg::H_IDLE: if (CMD_GO) begin
          BUSY <= 1'b1;
          NACK <= 1'b0;
          rd_reg <= CMD_READ;
          ad_reg <= CMD_AD_SEL;
          ad_lvl_reg <= CMD_AD_SEL;
          ra_reg <= CMD_REG;
          wd_reg <= CMD_WDATA;
          {q_reg, b_reg, k_reg, n_reg} <= 15'h0000;
          ssh_reg <= {CMD_READ, CMD_REG, CMD_WDATA};
          if (CMD_SPI) begin
            st_reg <= dsrs_pkg::H_SPI;
            cs_n_reg <= 1'b0;
          end else begin
            st_reg <= dsrs_pkg::H_TWI;
          end
        end
        dsrs_pkg::H_TWI: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              q_reg <= 2'h1;
              unique case (kind)
                dsrs_pkg::K_START: sda_oe_reg <= 1'b0;
                dsrs_pkg::K_TX: sda_oe_reg <= (b_reg != 4'h8)
                  && !sh_reg[7];
                dsrs_pkg::K_RX: sda_oe_reg <= 1'b0;
                dsrs_pkg::K_STOP: sda_oe_reg <= 1'b1;
              endcase
            end
            2'h1: begin
              scl_oe_reg <= 1'b0;
              q_reg <= 2'h2;
            end
            2'h2: if (scl_s[1]) begin
              q_reg <= 2'h3;
              if (kind == dsrs_pkg::K_START) begin
                sda_oe_reg <= 1'b1;
              end
              if (kind == dsrs_pkg::K_TX && b_reg == 4'h8 && sda_s[1]) begin
                NACK <= 1'b1;
              end
              if (kind == dsrs_pkg::K_RX && b_reg != 4'h8) begin
                RDATA <= {RDATA[6:0], sda_s[1]};
              end
            end
            2'h3: begin
              q_reg <= 2'h0;
              if (kind == dsrs_pkg::K_STOP) begin
                sda_oe_reg <= 1'b0;
                st_reg <= dsrs_pkg::H_IDLE;
                BUSY <= 1'b0;
                DONE <= 1'b1;
              end else begin
                scl_oe_reg <= 1'b1;
                if (kind != dsrs_pkg::K_START && b_reg != 4'h8) begin
                  b_reg <= 4'(b_reg + 4'h1);
                  sh_reg <= {sh_reg[6:0], 1'b0};
                end else begin
                  b_reg <= 4'h0;
                  // A refused address or byte ends the transfer
                  k_reg <= (NACK && kind == dsrs_pkg::K_TX) ? 3'h6
                    : 3'(k_reg + 3'h1);
                  sh_reg <= it_n[7:0];
                end
              end
            end
          endcase
        end
        dsrs_pkg::H_SPI: if (tick) begin
          n_reg <= 6'(n_reg + 6'h01);
          if (n_reg == 6'h20) begin
            cs_n_reg <= 1'b1;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            RDATA <= ssh_reg[7:0];
            st_reg <= dsrs_pkg::H_IDLE;
            BUSY <= 1'b0;
            DONE <= 1'b1;
          end else if (!n_reg[0]) begin
            scl_oe_reg <= 1'b1;
            sda_oe_reg <= !ssh_reg[15];
          end else begin
            scl_oe_reg <= 1'b0;
            ssh_reg <= {ssh_reg[14:0], sdo_s[1]};
          end
        end
      endcase
    end
  end

  assign LINK.cs_n = cs_n_reg;
  assign LINK.h_scl_o = 1'b0;
  assign LINK.h_scl_oe = scl_oe_reg;
  assign LINK.h_sda_o = 1'b0;
  assign LINK.h_sda_oe = sda_oe_reg;
  assign LINK.ad_lvl = ad_lvl_reg;
endmodule // dsrs_host

/* File: verilog/dsrs_if.sv */
// Pins between the device and its master: CS, SCL/SCLK, SDA/SDI,
// address select/SDO and the interrupt pin. Assumes pull-ups on
// SCL, SDA and the interrupt line; resolves the wires from enables.
`timescale 1ns/10ps
interface dsrs_if;
  logic cs_n, h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, ad_lvl;
  logic d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, d_sdo_o, d_sdo_oe;
  logic irq_o, irq_oe;
  logic scl, sda, sdo_ad, irq;
  assign scl = !(h_scl_oe && !h_scl_o) && !(d_scl_oe && !d_scl_o);
  assign sda = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);
  assign sdo_ad = d_sdo_oe ? d_sdo_o : ad_lvl;
  assign irq = irq_oe ? irq_o : 1'b1;
  modport dev(input cs_n, scl, sda, sdo_ad,
    output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, d_sdo_o, d_sdo_oe,
    output irq_o, irq_oe);
  modport host(output cs_n, h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
    output ad_lvl, input scl, sda, sdo_ad, irq);
endinterface // dsrs_if

/* File: verilog/dsrs_params.svh */
// Constants for the dual serial register slave and its master end.
// Assumes a 50 MHz CLK on both ends.
`ifndef DSRS_PARAMS_SVH
`define DSRS_PARAMS_SVH
`define DSRS_ADDR_HI 6'h34
`define DSRS_REG_INT_CFG 7'h37
`define DSRS_REG_INT_EN 7'h38
`define DSRS_REG_INT_STAT 7'h3A
`define DSRS_REG_USER_CTRL 7'h6A
`define DSRS_TWI_DIS_BIT 4
`define DSRS_CFG_LOWACT_BIT 7
`define DSRS_CFG_OPEN_BIT 6
`define DSRS_CFG_PULSE_BIT 5
`define DSRS_CFG_ANYRD_BIT 4
`define DSRS_ST_DRDY 0
`define DSRS_ST_AUXERR 3
`define DSRS_ST_OVF 4
`define DSRS_ST_AUXDONE 6
`define DSRS_CLK_KHZ 50000
`define DSRS_I2C_KHZ 400
`define DSRS_SPI_KHZ 1000
`define DSRS_INT_PULSE_US 50
`define DSRS_INT_PULSE_CYC (`DSRS_INT_PULSE_US * `DSRS_CLK_KHZ / 1000)
`define DSRS_I2C_QTR_CYC \
  ((`DSRS_CLK_KHZ + 4 * `DSRS_I2C_KHZ - 1) / (4 * `DSRS_I2C_KHZ))
`define DSRS_SPI_HALF_CYC \
  ((`DSRS_CLK_KHZ + 2 * `DSRS_SPI_KHZ - 1) / (2 * `DSRS_SPI_KHZ))
`define DSRS_STRETCH_CYC 4
`endif

/* File: verilog/dsrs_pkg.sv */
// Types shared by the device end and the master end.
// Assumes dsrs_params.svh for all numeric constants.
package dsrs_pkg;
  typedef enum logic [5:0] {
    I_IDLE = 6'h01, I_ADDR = 6'h02, I_RXRA = 6'h04,
    I_RXDAT = 6'h08, I_TX = 6'h10, I_SKIP = 6'h20
  } twi_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1, H_TWI = 3'h2, H_SPI = 3'h4
  } host_state_t;
  typedef enum logic [1:0] {
    K_START = 2'h0, K_TX = 2'h1, K_RX = 2'h2, K_STOP = 2'h3
  } item_kind_t;
endpackage
